/* verilog/rbc_pkg.sv */
// Package with register map, field layout and types of the baud and bit clock.
`default_nettype none
package rbc_pkg;
    localparam int          AXI_AW          = 8;
    localparam int          AXI_DW          = 32;

    // Register byte addresses.
    localparam logic [7:0]  ADDR_SYSCLK     = 8'h00;
    localparam logic [7:0]  ADDR_CMD_ONE    = 8'h04;
    localparam logic [7:0]  ADDR_CMD_TWO    = 8'h08;
    localparam logic [7:0]  ADDR_STATUS     = 8'h0c;

    // Field positions.
    localparam int          POS_EXT_REF     = 0;
    localparam int          POS_FINE        = 0;
    localparam int          POS_COARSE      = 4;
    localparam int          POS_ENC_EN      = 0;
    localparam int          POS_LINE_CODE   = 1;
    localparam int          POS_TXCLK_EN    = 4;
    localparam int          POS_RXCLK_EN    = 5;

    // Reset values.
    localparam logic [3:0]  RST_FINE        = 4'h0;
    localparam logic [1:0]  RST_COARSE      = 2'h0;
    localparam logic [2:0]  RST_LINE_CODE   = 3'h0;

    // Line codes below this value are NRZ variants; 11x is Miller.
    localparam logic [2:0]  CODE_FIRST_BIPH = 3'h3;

    // Chip prescaler: sixteen coarse stage wraps per chip, mid point at eight.
    localparam logic [3:0]  CHIP_LAST       = 4'hf;
    localparam logic [3:0]  CHIP_MID        = 4'h7;

    // Coarse terminal counts for factors 1, 4, 8 and 16.
    localparam logic [3:0]  COARSE_LAST_00  = 4'h0;
    localparam logic [3:0]  COARSE_LAST_01  = 4'h3;
    localparam logic [3:0]  COARSE_LAST_10  = 4'h7;
    localparam logic [3:0]  COARSE_LAST_11  = 4'hf;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_DECERR     = 2'h3;

    typedef struct packed {
        logic       ext_refclk_select;
        logic [3:0] fine_divider_code;
        logic [1:0] coarse_divider_code;
        logic       encoder_enable;
        logic [2:0] line_code_select;
        logic       tx_bitclk_out_enable;
        logic       rx_ext_bitclk_enable;
    } rbc_cfg_t;

    localparam rbc_cfg_t RST_CFG = '{
        ext_refclk_select:    1'b0,
        fine_divider_code:    RST_FINE,
        coarse_divider_code:  RST_COARSE,
        encoder_enable:       1'b0,
        line_code_select:     RST_LINE_CODE,
        tx_bitclk_out_enable: 1'b0,
        rx_ext_bitclk_enable: 1'b0
    };
endpackage
`default_nettype wire

/* verilog/rbc_div_stage.sv */
// Enabled modulo counter used for each stage of the baud divider chain.
`timescale 1ns/100ps
`default_nettype none
module rbc_div_stage (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       en,
    input  wire logic [3:0] last,
    output logic      [3:0] count,
    output logic            wrap
);
    // Wrap is combinational so a chain of stages advances in one cycle.
    assign wrap = en && (count >= last);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            count <= 4'h0;
        end else if (wrap) begin
            count <= 4'h0;
        end else if (en) begin
            count <= count + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* verilog/rbc_baud_bitclk.sv */
// Baud generator, transmit bit clock output and receive sampling strobe.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1 - Bit clock pin runs only when encoder bypassed or an NRZ code chosen.
// R2 - Bit clock pin is driven only while its enable bit is set.
// R3 - A config bit picks RC oscillator or external clock as reference.
// R4 - Chip rate is reference over fine times coarse times sixteen; an external reference is halved first here.
// R5 - Fine factor equals the four-bit code plus one, one to sixteen.
// R6 - Coarse codes 00, 01, 10, 11 give factors 1, 4, 8, 16.
// R7 - Divider gives chip rate; Manchester and Miller bits span two chips.
// R8 - Software should program the divider even with external receive clock.
// R9 - Receive tolerance depends on code; mid-chip sampling gives the margin.
// R10 - Uncoded NRZ without external clock survives ten equal bits at 4%.
// R11 - Transceiver drives receive clock pin only if its synchronizer is used.
// R12 - Uncoded shifting runs at chip rate, twice data rate for biphase.
// R13 - Receive clock enable samples on the external clock instead.
// R14 - Bit clock makes one low and one high half per bit, data changes on its falling edge.
module rbc_baud_bitclk
    import rbc_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire logic                 rc_osc_tick,
    input  wire logic                 ext_clk_tick,
    input  wire logic                 radio_rx_clock_pin,
    output logic                      radio_tx_clock_pin,
    output logic                      radio_tx_clock_oe,
    output logic                      tx_shift_strobe,
    output logic                      rx_sample_strobe,
    output logic                      chip_strobe,
    input  wire logic [rbc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [rbc_pkg::AXI_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic      [1:0]           s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [rbc_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic      [rbc_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic      [1:0]           s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);
    import rbc_pkg::*;

    rbc_cfg_t           cfg;
    logic [AXI_AW-1:0]  wr_addr;
    logic [AXI_DW-1:0]  wr_data;
    logic               have_aw;
    logic               have_w;
    logic               ext_half;
    logic               rx_clk_prev;
    logic               chip_phase;

    // ---------------- AXI4-Lite write path ----------------
    wire take_aw   = s_axi_awvalid && s_axi_awready;
    wire take_w    = s_axi_wvalid && s_axi_wready;
    wire aw_done   = have_aw || take_aw;
    wire w_done    = have_w || take_w;
    wire do_write  = aw_done && w_done && !s_axi_bvalid;
    wire [AXI_AW-1:0] eff_waddr = have_aw ? wr_addr : s_axi_awaddr;
    wire [AXI_DW-1:0] eff_wdata = have_w ? wr_data : s_axi_wdata;
    wire              eff_lane0 = have_w ? 1'b1 : s_axi_wstrb[0];
    wire hit_sysclk_w = (eff_waddr == ADDR_SYSCLK);
    wire hit_cmd1_w   = (eff_waddr == ADDR_CMD_ONE);
    wire hit_cmd2_w   = (eff_waddr == ADDR_CMD_TWO);
    wire hit_stat_w   = (eff_waddr == ADDR_STATUS);
    wire wr_mapped    = hit_sysclk_w || hit_cmd1_w || hit_cmd2_w || hit_stat_w;
    wire wr_lane_ok   = eff_lane0;
    logic lane0_held;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            have_aw    <= 1'b0;
            have_w     <= 1'b0;
            wr_addr    <= '0;
            wr_data    <= '0;
            lane0_held <= 1'b0;
        end else if (do_write) begin
            have_aw    <= 1'b0;
            have_w     <= 1'b0;
        end else begin
            if (take_aw) begin
                have_aw <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (take_w) begin
                have_w     <= 1'b1;
                wr_data    <= s_axi_wdata;
                lane0_held <= s_axi_wstrb[0];
            end
        end
    end

    // Held data keeps its own byte enable so a late address still sees it.
    wire lane0 = have_w ? lane0_held : wr_lane_ok;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_done && !s_axi_bvalid;
            s_axi_wready  <= !w_done && !s_axi_bvalid;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Only byte lane 0 carries fields; the status word ignores writes.
    wire cfg_we = do_write && lane0;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cfg <= RST_CFG;
        end else if (cfg_we) begin
            if (hit_sysclk_w) begin
                cfg.ext_refclk_select <= eff_wdata[POS_EXT_REF];  // [R3]
            end else if (hit_cmd1_w) begin
                cfg.fine_divider_code   <= eff_wdata[POS_FINE +: 4];
                cfg.coarse_divider_code <= eff_wdata[POS_COARSE +: 2];
            end else if (hit_cmd2_w) begin
                cfg.encoder_enable       <= eff_wdata[POS_ENC_EN];
                cfg.line_code_select     <= eff_wdata[POS_LINE_CODE +: 3];
                cfg.tx_bitclk_out_enable <= eff_wdata[POS_TXCLK_EN];
                cfg.rx_ext_bitclk_enable <= eff_wdata[POS_RXCLK_EN];
            end
        end
    end

    // ---------------- Reference and divider chain ----------------
    // The external clock is halved before use, the RC tick is used as is.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ext_half <= 1'b0;
        end else if (ext_clk_tick) begin
            ext_half <= !ext_half;
        end
    end

    wire ref_tick = cfg.ext_refclk_select ? (ext_clk_tick && ext_half)
                                          : rc_osc_tick;  // [R3] [R4]

    wire [3:0] coarse_last =
        (cfg.coarse_divider_code == 2'b00) ? COARSE_LAST_00 :
        (cfg.coarse_divider_code == 2'b01) ? COARSE_LAST_01 :
        (cfg.coarse_divider_code == 2'b10) ? COARSE_LAST_10 :
                                             COARSE_LAST_11;  // [R6]

    logic [3:0] fine_count;
    logic [3:0] coarse_count;
    logic [3:0] chip_count;
    logic       fine_wrap;
    logic       coarse_wrap;
    logic       chip_wrap;

    // Terminal count equal to the code gives code plus one steps. [R5]
    rbc_div_stage u_fine (
        .mclk   (mclk),
        .resetn (resetn),
        .en     (ref_tick),
        .last   (cfg.fine_divider_code),
        .count  (fine_count),
        .wrap   (fine_wrap)
    );

    rbc_div_stage u_coarse (
        .mclk   (mclk),
        .resetn (resetn),
        .en     (fine_wrap),
        .last   (coarse_last),
        .count  (coarse_count),
        .wrap   (coarse_wrap)
    );

    // Final divide by sixteen yields one chip per wrap. [R4]
    rbc_div_stage u_chip (
        .mclk   (mclk),
        .resetn (resetn),
        .en     (coarse_wrap),
        .last   (CHIP_LAST),
        .count  (chip_count),
        .wrap   (chip_wrap)
    );

    wire chip_mid = coarse_wrap && (chip_count == CHIP_MID);

    // ---------------- Code dependent bit timing ----------------
    wire code_is_nrz = (cfg.line_code_select < CODE_FIRST_BIPH);
    wire two_chips   = cfg.encoder_enable && !code_is_nrz;  // [R7]

    // Chip phase marks the second chip of a two-chip bit.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            chip_phase <= 1'b0;
        end else if (!two_chips) begin
            chip_phase <= 1'b0;
        end else if (chip_wrap) begin
            chip_phase <= !chip_phase;  // [R7]
        end
    end

    // Uncoded output shifts every chip, which is twice the data rate of a
    // biphase line code and the data rate of NRZ. [R12]
    wire bit_start = chip_wrap && (!two_chips || chip_phase);

    // The pin clock exists only when each bit is exactly one chip.
    wire clk_allowed = cfg.tx_bitclk_out_enable &&
                       (!cfg.encoder_enable || code_is_nrz);  // [R1] [R2]

    // Receiver strobe: mid-chip sampling on the internal rate gives the
    // widest margin against rate mismatch; the external pin clock is taken
    // on its rising edge when selected. [R9] [R10] [R13]
    wire rx_ext_rise = radio_rx_clock_pin && !rx_clk_prev;
    wire rx_strobe_n = cfg.rx_ext_bitclk_enable ? rx_ext_rise : chip_mid;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rx_clk_prev <= 1'b0;
        end else begin
            rx_clk_prev <= radio_rx_clock_pin;
        end
    end

    // ---------------- Registered outputs ----------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            radio_tx_clock_pin <= 1'b0;
            radio_tx_clock_oe  <= 1'b0;
            tx_shift_strobe    <= 1'b0;
            rx_sample_strobe   <= 1'b0;
            chip_strobe        <= 1'b0;
        end else begin
            radio_tx_clock_oe <= clk_allowed;  // [R2]
            if (!clk_allowed) begin
                radio_tx_clock_pin <= 1'b0;  // [R1] [R2]
            end else if (bit_start) begin
                radio_tx_clock_pin <= 1'b0;  // [R14]
            end else if (chip_mid) begin
                radio_tx_clock_pin <= 1'b1;  // [R14]
            end
            // New data leaves with the falling edge, stable at the rise.
            tx_shift_strobe  <= bit_start;  // [R14]
            rx_sample_strobe <= rx_strobe_n;
            chip_strobe      <= chip_wrap;
        end
    end

    // ---------------- AXI4-Lite read path ----------------
    wire [AXI_AW-1:0] raddr = s_axi_araddr;
    wire take_ar      = s_axi_arvalid && s_axi_arready;
    wire hit_sysclk_r = (raddr == ADDR_SYSCLK);
    wire hit_cmd1_r   = (raddr == ADDR_CMD_ONE);
    wire hit_cmd2_r   = (raddr == ADDR_CMD_TWO);
    wire hit_stat_r   = (raddr == ADDR_STATUS);

    wire [AXI_DW-1:0] word_sysclk = {31'h0, cfg.ext_refclk_select};
    wire [AXI_DW-1:0] word_cmd1   = {26'h0, cfg.coarse_divider_code,
                                     cfg.fine_divider_code};
    wire [AXI_DW-1:0] word_cmd2   = {26'h0, cfg.rx_ext_bitclk_enable,
                                     cfg.tx_bitclk_out_enable,
                                     cfg.line_code_select,
                                     cfg.encoder_enable};
    wire [AXI_DW-1:0] word_status = {20'h0, chip_count, coarse_count,
                                     chip_phase, cfg.rx_ext_bitclk_enable,
                                     radio_tx_clock_pin, radio_tx_clock_oe};

    wire [AXI_DW-1:0] rd_word =
        hit_sysclk_r ? word_sysclk :
        hit_cmd1_r   ? word_cmd1   :
        hit_cmd2_r   ? word_cmd2   :
        hit_stat_r   ? word_status : '0;
    wire rd_mapped = hit_sysclk_r || hit_cmd1_r || hit_cmd2_r || hit_stat_r;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !take_ar;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (take_ar) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* test/rbc_checker.sv */
// Checker for bit clock pin timing and bus handshakes of the baud block.
`timescale 1ns/100ps
`default_nettype none
module rbc_checker (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic radio_tx_clock_pin,
    input  wire logic radio_tx_clock_oe,
    input  wire logic tx_shift_strobe,
    input  wire logic chip_strobe,
    input  wire logic s_axi_awvalid,
    input  wire logic s_axi_awready,
    input  wire logic s_axi_wvalid,
    input  wire logic s_axi_wready,
    input  wire logic s_axi_bvalid,
    input  wire logic s_axi_bready,
    input  wire logic s_axi_arvalid,
    input  wire logic s_axi_arready,
    input  wire logic s_axi_rvalid,
    input  wire logic s_axi_rready
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_pin_idle_low: assert property (
        !radio_tx_clock_oe |-> !radio_tx_clock_pin)
        else $error("tx clock pin high while not driven");
    // Chip strobes are never fewer than sixteen clock cycles apart.
    a_chip_gap_min: assert property (
        chip_strobe |=> !chip_strobe [*8] ##1 !chip_strobe [*7])
        else $error("chip strobes closer than sixteen cycles");
    a_shift_gap_min: assert property (
        tx_shift_strobe |=>
            !tx_shift_strobe [*8] ##1 !tx_shift_strobe [*7])
        else $error("shift strobes closer than one chip");
    a_pin_low_start: assert property (
        tx_shift_strobe && radio_tx_clock_oe |-> !radio_tx_clock_pin)
        else $error("tx clock pin high at bit start");
    a_pin_low_span: assert property (
        $fell(radio_tx_clock_pin) && tx_shift_strobe
            |=> !radio_tx_clock_pin [*6])
        else $error("tx clock pin rose too early in the bit");
    a_ready_after_rst: assert property (
        $rose(resetn) |=> s_axi_awready && s_axi_arready)
        else $error("bus not ready after reset release");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> s_axi_bvalid)
        else $error("write response late");
    a_bvalid_drop: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rvalid_drop: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
        else $error("read channel not released");
endmodule
`default_nettype wire

/* test/rbc_radio_model.sv */
// Transceiver model that supplies the receive bit synchronizer clock.
`timescale 1ns/100ps
`default_nettype none
module rbc_radio_model #(
    parameter int HALF = 10
) (
    input  wire logic mclk,
    input  wire logic sync_on,
    output logic      radio_rx_clock_pin
);
    int   cnt = 0;
    logic clk_q = 1'b0;
    logic pin_q = 1'b0;

    assign radio_rx_clock_pin = pin_q;

    // With its synchronizer unused the link is left open, so the pin is shown
    // flipping every cycle rather than holding a value the block could trust.
    always @(posedge mclk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) clk_q <= ~clk_q;
        pin_q <= sync_on ? clk_q : ~pin_q;
    end
endmodule
`default_nettype wire

/* test/radio_if_baud_and_bit_clock_tb.sv */
// Self-checking bench for the baud generator and transmit bit clock.
`timescale 1ns/100ps
`default_nettype none
module radio_if_baud_and_bit_clock_tb;
    import rbc_pkg::*;
    logic        mclk, resetn, rc_osc_tick, ext_clk_tick, sync_on, pin_q;
    logic        radio_rx_clock_pin, radio_tx_clock_pin, radio_tx_clock_oe;
    logic        tx_shift_strobe, rx_sample_strobe, chip_strobe;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, mon, c;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          errors, checks_done, i;
    logic [3:0]  fin [5] = '{4'h0, 4'h3, 4'hf, 4'h1, 4'hf};
    logic [1:0]  crs [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    int          cfac [4] = '{1, 4, 8, 16};
    logic [31:0] sh_cmd [4] = '{32'h10, 32'h07, 32'h06, 32'h0d};
    int          sh_per [4] = '{16, 32, 16, 32};

    rbc_baud_bitclk u_rbc_baud_bitclk (.mclk(mclk), .resetn(resetn),
        .rc_osc_tick(rc_osc_tick), .ext_clk_tick(ext_clk_tick),
        .radio_rx_clock_pin(radio_rx_clock_pin),
        .radio_tx_clock_pin(radio_tx_clock_pin),
        .radio_tx_clock_oe(radio_tx_clock_oe),
        .tx_shift_strobe(tx_shift_strobe), .rx_sample_strobe(rx_sample_strobe),
        .chip_strobe(chip_strobe), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    rbc_radio_model u_rbc_radio_model (.mclk(mclk), .sync_on(sync_on),
        .radio_rx_clock_pin(radio_rx_clock_pin));

    assign mon = {pin_q & ~radio_tx_clock_pin, rx_sample_strobe,
                  tx_shift_strobe, chip_strobe};

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(negedge mclk) pin_q <= radio_tx_clock_pin;

    task summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task hang();
        errors++;
        summarize();
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        bready <= 1'b0;
        if (!bvalid) hang();
        chk({30'h0, bresp}, {30'h0, r});
    endtask

    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        rready <= 1'b0;
        if (!rvalid) hang();
        chk(rdata, d);
        chk({30'h0, rresp}, {30'h0, r});
    endtask

    // Skips two pulses so a period cut short by reprogramming is not measured.
    task measure(input int sel, input int exp);
        int n, k, len;
        k = 0;
        len = 0;
        for (n = 0; n < 20000 && k < 3; n++) begin
            @(negedge mclk);
            if (k == 2) len++;
            if (mon[sel]) k++;
        end
        if (k < 3) hang();
        chk(32'(len), 32'(exp));
    endtask

    // Cycles from a pulse on one monitor bit to the next pulse on another.
    task offset(input int src, input int dst, input int exp);
        int n, len;
        len = -1;
        for (n = 0; n < 20000 && !(len > 0 && mon[dst]); n++) begin
            @(negedge mclk);
            if (len >= 0) len++;
            if (len < 0 && mon[src]) len = 0;
        end
        if (!(len > 0 && mon[dst])) hang();
        chk(32'(len), 32'(exp));
    endtask

    initial begin
        {resetn, awvalid, wvalid, bready, arvalid, rready, sync_on} = '0;
        {awaddr, araddr, wdata, ext_clk_tick} = '0;
        rc_osc_tick = 1'b1;
        wstrb = 4'hf;
        errors = 0;
        checks_done = 0;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        rd(ADDR_SYSCLK, 32'h0, RESP_OKAY);
        rd(ADDR_CMD_ONE, 32'h0, RESP_OKAY);
        rd(ADDR_CMD_TWO, 32'h0, RESP_OKAY);
        rd(8'h10, 32'h0, RESP_DECERR);
        wr(8'h10, 32'hff, RESP_DECERR);
        wr(ADDR_CMD_ONE, 32'h3f, RESP_OKAY);
        rd(ADDR_CMD_ONE, 32'h3f, RESP_OKAY);
        wr(ADDR_STATUS, 32'h0, RESP_OKAY);
        wstrb <= 4'he;
        wr(ADDR_CMD_ONE, 32'h0, RESP_OKAY);
        wstrb <= 4'hf;
        rd(ADDR_CMD_ONE, 32'h3f, RESP_OKAY);
        $display("test registers done");
        for (i = 0; i < 5; i++) begin
            wr(ADDR_CMD_ONE, {26'h0, crs[i], fin[i]}, RESP_OKAY);
            measure(0, (int'(fin[i]) + 1) * cfac[crs[i]] * 16);
        end
        wr(ADDR_CMD_ONE, 32'h0, RESP_OKAY);
        @(posedge mclk);
        ext_clk_tick <= 1'b1;
        wr(ADDR_SYSCLK, 32'h1, RESP_OKAY);
        measure(0, 32);
        wr(ADDR_SYSCLK, 32'h0, RESP_OKAY);
        $display("test dividers done");
        for (i = 0; i < 16; i++) begin
            c = i[3:0];
            wr(ADDR_CMD_TWO, 32'h10 + 32'(c), RESP_OKAY);
            repeat (2) @(negedge mclk);
            chk({31'h0, radio_tx_clock_oe},
                {31'h0, !c[0] || c[3:1] < 3'h3});
        end
        wr(ADDR_CMD_TWO, 32'h0, RESP_OKAY);
        repeat (2) @(negedge mclk);
        chk({31'h0, radio_tx_clock_oe}, 32'h0);
        $display("test clock enable done");
        for (i = 0; i < 4; i++) begin
            wr(ADDR_CMD_TWO, sh_cmd[i], RESP_OKAY);
            measure(1, sh_per[i]);
        end
        wr(ADDR_CMD_TWO, 32'h10, RESP_OKAY);
        measure(3, 16);
        $display("test shifting done");
        wr(ADDR_CMD_ONE, 32'h0, RESP_OKAY);
        wr(ADDR_CMD_TWO, 32'h0, RESP_OKAY);
        measure(2, 16);
        offset(0, 2, 8);
        @(posedge mclk);
        sync_on <= 1'b1;
        wr(ADDR_CMD_TWO, 32'h20, RESP_OKAY);
        measure(2, 20);
        $display("test receive clock done");
        summarize();
    end
endmodule

bind rbc_baud_bitclk rbc_checker u_rbc_checker (.mclk(mclk), .resetn(resetn),
    .radio_tx_clock_pin(radio_tx_clock_pin),
    .radio_tx_clock_oe(radio_tx_clock_oe), .tx_shift_strobe(tx_shift_strobe),
    .chip_strobe(chip_strobe), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
`default_nettype wire
